// >>> scp_pkg.sv
// constants, register map and types of the safe channel passivation block
`default_nettype none
package scp_pkg;
   localparam int unsigned NUM_IN   = 8;
   localparam int unsigned NUM_PAIR = 4;
   localparam int unsigned NUM_OUT  = 4;
   localparam int unsigned NUM_SYNC = 29;

   // timing
   localparam int unsigned CLK_NS         = 50;
   localparam int unsigned READBACK_US    = 100;
   localparam int unsigned READBACK_CYC   = READBACK_US * 1000 / CLK_NS;
   localparam int unsigned MS_NS          = 1000000;
   localparam int unsigned MS_CYC         = MS_NS / CLK_NS;
   localparam int unsigned TEST_PERIOD_MS = 100;
   localparam int unsigned TEST_PERIOD_CYC = TEST_PERIOD_MS * MS_CYC;
   localparam int unsigned GAP_NS         = 1000;
   localparam int unsigned GAP_CYC        = GAP_NS / CLK_NS;

   // register byte offsets
   localparam logic [7:0] REG_CH_EN     = 8'h00;
   localparam logic [7:0] REG_IN_MODE   = 8'h04;
   localparam logic [7:0] REG_DISC_TIME = 8'h08;
   localparam logic [7:0] REG_OUT_VAL   = 8'h0C;
   localparam logic [7:0] REG_IN_PV     = 8'h10;
   localparam logic [7:0] REG_VSTAT     = 8'h14;
   localparam logic [7:0] REG_PAS       = 8'h18;
   localparam logic [7:0] REG_REINT     = 8'h1C;
   localparam logic [7:0] REG_IRQ_STAT  = 8'h20;
   localparam logic [7:0] REG_IRQ_MASK  = 8'h24;
   localparam logic [7:0] REG_TEST_STAT = 8'h28;

   // field positions
   localparam int unsigned OUT_FIELD_LSB = 8;
   localparam int unsigned MOD_FIELD_BIT = 16;
   localparam int unsigned NEQ_FIELD_LSB = 4;

   // reset values
   localparam logic [11:0] CH_EN_RST     = 12'hFFF;
   localparam logic [7:0]  IN_MODE_RST   = 8'h00;
   localparam logic [15:0] DISC_TIME_RST = 16'h000A;
   localparam logic [3:0]  OUT_VAL_RST   = 4'h0;
   localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;

   // interrupt event bits
   localparam int unsigned EV_IN_PAS  = 0;
   localparam int unsigned EV_OUT_PAS = 1;
   localparam int unsigned EV_MOD_PAS = 2;
   localparam int unsigned EV_REINT   = 3;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_P_ON = 2'b01,
      ST_GAP  = 2'b11,
      ST_M_ON = 2'b10
   } scp_test_t;

   // inputs of a pair disagree: equal for non-equivalent, unequal else
   function automatic logic pair_disagree(input logic a,
                                          input logic b,
                                          input logic neq);
      pair_disagree = neq ? (a == b) : (a != b);
   endfunction
endpackage
`default_nettype wire

// >>> scp_sync.sv
// two flip-flop synchroniser for pin inputs
`default_nettype none
module scp_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= '0;
         q      <= '0;
      end
      else
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

// >>> scp_disc.sv
// discrepancy timer of one redundant input pair
`default_nettype none
module scp_disc (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // control
   input  wire logic        enable,
   input  wire logic        disagree,
   input  wire logic        tick_ms,
   input  wire logic [15:0] limit_ms,
   // result
   output logic             fault
);
   logic [15:0] cnt_q;
   logic        run;
   logic        expired;

   assign run     = enable & disagree;
   assign expired = (cnt_q >= limit_ms);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= 16'h0000;
         fault <= 1'b0;
      end
      else
      begin
         if (!run)
            cnt_q <= 16'h0000;
         else if (tick_ms && !expired)
            cnt_q <= cnt_q + 16'h0001;
         fault <= run & expired; // RULE_12
      end
   end
endmodule
`default_nettype wire

// >>> scp_top.sv
// channel passivation, value status, redundant inputs and output tests
// What this block does
// (RULE_01) faulty channel or module delivers safe 0
// (RULE_02) passivated input reads process value 0
// (RULE_03) passivated output ignores commanded 1
// (RULE_04) value status 0 when passivated or deactivated
// (RULE_05) redundant pair upper status bit always 0
// (RULE_06) module fault passivates every channel
// (RULE_07) non-equivalent: first high 1, second high 0
// (RULE_08) no test drives both switches at 0
// (RULE_09) single-switch test pulses within readback time
// (RULE_10) zero, de-energized, is the safe state
// (RULE_11) leave passivation only by reintegration
// (RULE_12) pair disagreement beyond discrepancy time faults
// (RULE_13) equivalent: both high 1, both low 0
// (RULE_14) passivation holds until reintegration completes
`default_nettype none
module scp_top #(
   parameter int unsigned MS_CYC_P      = scp_pkg::MS_CYC,
   parameter int unsigned TEST_PERIOD_P = scp_pkg::TEST_PERIOD_CYC
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // input terminals and their diagnostics
   input  wire logic [7:0]  in_pin,
   input  wire logic [7:0]  in_wire_fault,
   // dual switch outputs
   output logic      [3:0]  out_p,
   output logic      [3:0]  out_m,
   input  wire logic [3:0]  out_p_fb,
   input  wire logic [3:0]  out_m_fb,
   input  wire logic [3:0]  out_diag_fault,
   // module level
   input  wire logic        mod_fault,
   output logic             irq
);
   localparam logic [11:0] PULSE_LAST = 12'(scp_pkg::READBACK_CYC - 1);
   localparam logic [11:0] GAP_LAST   = 12'(scp_pkg::GAP_CYC - 1);
   localparam logic [14:0] MS_LAST    = 15'(MS_CYC_P - 1);
   localparam logic [23:0] PER_LAST   = 24'(TEST_PERIOD_P - 1);

   // synchronised pins
   logic [28:0] sync_q;
   logic [7:0]  in_s;
   logic [7:0]  wf_s;
   logic [3:0]  pfb_s;
   logic [3:0]  mfb_s;
   logic [3:0]  diag_s;
   logic        mod_s;

   scp_sync #(
      .W (scp_pkg::NUM_SYNC)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({mod_fault, out_diag_fault, out_m_fb, out_p_fb,
              in_wire_fault, in_pin}),
      .q   (sync_q)
   );

   assign in_s   = sync_q[7:0];
   assign wf_s   = sync_q[15:8];
   assign pfb_s  = sync_q[19:16];
   assign mfb_s  = sync_q[23:20];
   assign diag_s = sync_q[27:24];
   assign mod_s  = sync_q[28];

   // registers
   logic [11:0]        ch_en_q;
   logic [7:0]         in_mode_q;
   logic [15:0]        disc_time_q;
   logic [3:0]         out_val_q;
   logic [7:0]         pv_in_q;
   logic [11:0]        vstat_q;
   logic [7:0]         pas_in_q;
   logic [3:0]         pas_out_q;
   logic               mod_pas_q;
   logic [3:0]         irq_stat_q;
   logic [3:0]         irq_mask_q;
   scp_pkg::scp_test_t state_q;
   logic [11:0]        tcnt_q;
   logic [3:0]         tmask_q;
   logic [23:0]        pcnt_q;
   logic [14:0]        ms_cnt_q;

   // write decode
   wire wr_en    = reg_wr & (reg_addr == scp_pkg::REG_CH_EN);
   wire wr_mode  = reg_wr & (reg_addr == scp_pkg::REG_IN_MODE);
   wire wr_disc  = reg_wr & (reg_addr == scp_pkg::REG_DISC_TIME);
   wire wr_oval  = reg_wr & (reg_addr == scp_pkg::REG_OUT_VAL);
   wire wr_reint = reg_wr & (reg_addr == scp_pkg::REG_REINT);
   wire wr_stat  = reg_wr & (reg_addr == scp_pkg::REG_IRQ_STAT);
   wire wr_mask  = reg_wr & (reg_addr == scp_pkg::REG_IRQ_MASK);

   wire [7:0] en_in  = ch_en_q[7:0];
   wire [3:0] en_out = ch_en_q[11:8];
   wire [7:0] reint_in  = wr_reint ? reg_wdata[7:0] : 8'h00;
   wire [3:0] reint_out = wr_reint ? reg_wdata[11:8] : 4'h0;
   wire       reint_mod = wr_reint & reg_wdata[scp_pkg::MOD_FIELD_BIT];

   // millisecond tick for the discrepancy timers
   wire tick_ms = (ms_cnt_q == MS_LAST);

   // redundant pair evaluation
   logic [7:0] raw_pv;
   logic [7:0] in_fault;
   logic [7:0] vmask;

   genvar p;
   generate
      for (p = 0; p < scp_pkg::NUM_PAIR; p++)
      begin : g_pair
         wire a   = in_s[2*p];
         wire b   = in_s[2*p+1];
         wire red = in_mode_q[p];
         wire neq = in_mode_q[scp_pkg::NEQ_FIELD_LSB + p];
         wire dis = scp_pkg::pair_disagree(a, b, neq);
         // agreement: value follows the first input in both modes
         wire pair_val = a & ~dis; // RULE_07 RULE_13
         wire disc_f;

         scp_disc u_disc (
            .clk      (clk),
            .rst      (rst),
            .enable   (red),
            .disagree (dis),
            .tick_ms  (tick_ms),
            .limit_ms (disc_time_q),
            .fault    (disc_f)
         );

         assign raw_pv[2*p]     = red ? pair_val : a;
         assign raw_pv[2*p+1]   = red ? 1'b0 : b;
         assign in_fault[2*p]   = wf_s[2*p]
                                | (red & (wf_s[2*p+1] | disc_f)); // RULE_12
         assign in_fault[2*p+1] = ~red & wf_s[2*p+1];
         assign vmask[2*p]      = 1'b1;
         assign vmask[2*p+1]    = ~red; // RULE_05
      end
   endgenerate

   // passivation state, module fault covers every channel
   wire [7:0] pas_in_eff  = pas_in_q | {8{mod_pas_q}}; // RULE_06
   wire [3:0] pas_out_eff = pas_out_q | {4{mod_pas_q}}; // RULE_06

   // output test sequencer
   wire       per_done = (pcnt_q == PER_LAST);
   wire [3:0] cmd      = out_val_q & en_out & ~pas_out_eff; // RULE_03
   wire [3:0] cand     = en_out & ~pas_out_eff & ~out_val_q;
   wire       in_p     = (state_q == scp_pkg::ST_P_ON);
   wire       in_m     = (state_q == scp_pkg::ST_M_ON);
   wire       cnt_end  = (tcnt_q == ((state_q == scp_pkg::ST_GAP)
                                     ? GAP_LAST : PULSE_LAST));
   wire [3:0] tlive    = tmask_q & ~cmd & cand;
   wire [3:0] test_f   = (in_p & cnt_end) ? (tlive & ~pfb_s)
                       : (in_m & cnt_end) ? (tlive & ~mfb_s)
                       : 4'h0;
   // only one switch per test phase, never both at a 0 command
   wire [3:0] p_d = cmd | (tlive & {4{in_p}}); // RULE_08 RULE_09
   wire [3:0] m_d = cmd | (tlive & {4{in_m}}); // RULE_08 RULE_09

   // fault and passivation next state, a new fault wins over reintegration
   wire [3:0] out_fault = diag_s | test_f;
   wire [7:0] pas_in_d  = (pas_in_q & ~(reint_in & ~in_fault))
                        | in_fault; // RULE_11 RULE_14
   wire [3:0] pas_out_d = (pas_out_q & ~(reint_out & ~diag_s))
                        | out_fault; // RULE_11 RULE_14
   wire       mod_pas_d = (mod_pas_q & ~(reint_mod & ~mod_s))
                        | mod_s; // RULE_11 RULE_14

   // process values and value status
   wire [7:0]  pv_d    = raw_pv & en_in & ~pas_in_eff; // RULE_01 RULE_02
   wire [11:0] vstat_d = {en_out & ~pas_out_eff,
                          en_in & ~pas_in_eff & vmask}; // RULE_04

   // interrupt events
   logic [3:0] ev;
   assign ev[scp_pkg::EV_IN_PAS]  = |(in_fault & ~pas_in_q);
   assign ev[scp_pkg::EV_OUT_PAS] = |(out_fault & ~pas_out_q);
   assign ev[scp_pkg::EV_MOD_PAS] = mod_s & ~mod_pas_q;
   assign ev[scp_pkg::EV_REINT]   = |(pas_in_q & ~pas_in_d)
                                  | |(pas_out_q & ~pas_out_d)
                                  | (mod_pas_q & ~mod_pas_d);
   wire [3:0] stat_clr   = wr_stat ? reg_wdata[3:0] : 4'h0;
   wire [3:0] irq_stat_d = (irq_stat_q & ~stat_clr) | ev;

   // read selection
   logic [31:0] rd_mux;
   assign rd_mux =
      (reg_addr == scp_pkg::REG_CH_EN)     ? {20'h00000, ch_en_q} :
      (reg_addr == scp_pkg::REG_IN_MODE)   ? {24'h000000, in_mode_q} :
      (reg_addr == scp_pkg::REG_DISC_TIME) ? {16'h0000, disc_time_q} :
      (reg_addr == scp_pkg::REG_OUT_VAL)   ? {28'h0000000, out_val_q} :
      (reg_addr == scp_pkg::REG_IN_PV)     ? {24'h000000, pv_in_q} :
      (reg_addr == scp_pkg::REG_VSTAT)     ? {20'h00000, vstat_q} :
      (reg_addr == scp_pkg::REG_PAS)       ? {15'h0000, mod_pas_q,
                                              4'h0, pas_out_q, pas_in_q} :
      (reg_addr == scp_pkg::REG_IRQ_STAT)  ? {28'h0000000, irq_stat_q} :
      (reg_addr == scp_pkg::REG_IRQ_MASK)  ? {28'h0000000, irq_mask_q} :
      (reg_addr == scp_pkg::REG_TEST_STAT) ? {24'h000000, tmask_q,
                                              2'b00, state_q} :
      32'h00000000;

   // configuration and bus read data
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ch_en_q     <= scp_pkg::CH_EN_RST;
         in_mode_q   <= scp_pkg::IN_MODE_RST;
         disc_time_q <= scp_pkg::DISC_TIME_RST;
         out_val_q   <= scp_pkg::OUT_VAL_RST;
         irq_mask_q  <= scp_pkg::IRQ_MASK_RST;
         reg_rdata   <= 32'h00000000;
      end
      else
      begin
         if (wr_en)
            ch_en_q <= reg_wdata[11:0];
         if (wr_mode)
            in_mode_q <= reg_wdata[7:0];
         if (wr_disc)
            disc_time_q <= reg_wdata[15:0];
         if (wr_oval)
            out_val_q <= reg_wdata[3:0];
         if (wr_mask)
            irq_mask_q <= reg_wdata[3:0];
         reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
      end
   end

   // channel state, all safe at reset
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pas_in_q   <= 8'h00;
         pas_out_q  <= 4'h0;
         mod_pas_q  <= 1'b0;
         pv_in_q    <= 8'h00; // RULE_10
         vstat_q    <= 12'h000;
         out_p      <= 4'h0; // RULE_10
         out_m      <= 4'h0; // RULE_10
         irq_stat_q <= 4'h0;
         irq        <= 1'b0;
      end
      else
      begin
         pas_in_q   <= pas_in_d;
         pas_out_q  <= pas_out_d;
         mod_pas_q  <= mod_pas_d;
         pv_in_q    <= pv_d;
         vstat_q    <= vstat_d;
         out_p      <= p_d;
         out_m      <= m_d;
         irq_stat_q <= irq_stat_d;
         irq        <= |(irq_stat_d & irq_mask_q);
      end
   end

   // dividers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ms_cnt_q <= 15'h0000;
         pcnt_q   <= 24'h000000;
      end
      else
      begin
         ms_cnt_q <= tick_ms ? 15'h0000 : ms_cnt_q + 15'h0001;
         pcnt_q   <= per_done ? 24'h000000 : pcnt_q + 24'h000001;
      end
   end

   // test phases: P pulse, gap, M pulse
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= scp_pkg::ST_IDLE;
         tcnt_q  <= 12'h000;
         tmask_q <= 4'h0;
      end
      else
      begin
         tcnt_q <= (cnt_end || state_q == scp_pkg::ST_IDLE)
                   ? 12'h000 : tcnt_q + 12'h001; // RULE_09
         unique case (state_q)
            scp_pkg::ST_IDLE:
            begin
               if (per_done && (|cand))
               begin
                  state_q <= scp_pkg::ST_P_ON;
                  tmask_q <= cand;
               end
            end
            scp_pkg::ST_P_ON:
            begin
               if (cnt_end)
                  state_q <= scp_pkg::ST_GAP;
            end
            scp_pkg::ST_GAP:
            begin
               if (cnt_end)
                  state_q <= scp_pkg::ST_M_ON;
            end
            scp_pkg::ST_M_ON:
            begin
               if (cnt_end)
               begin
                  state_q <= scp_pkg::ST_IDLE;
                  tmask_q <= 4'h0;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> scp_chk_sva.sv
// port assertions of the passivation block
`default_nettype none
module scp_chk (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // register port
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // pins
   input wire logic [7:0]  in_wire_fault,
   input wire logic [3:0]  out_p,
   input wire logic [3:0]  out_m,
   input wire logic        mod_fault,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]      hi_q;
   logic [3:0]      val_q;
   logic [3:0]      mask_q;
   logic [11:0]     len_q;
   wire logic       wr_m = reg_wr && reg_addr == scp_pkg::REG_IN_MODE;
   wire logic       wr_v = reg_wr && reg_addr == scp_pkg::REG_OUT_VAL;
   wire logic       wr_k = reg_wr && reg_addr == scp_pkg::REG_IRQ_MASK;
   wire logic [3:0] r = reg_wdata[3:0];

   // shadows of written registers, length of single-switch drive
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         hi_q   <= 8'h00;
         val_q  <= 4'h0;
         mask_q <= 4'h0;
         len_q  <= 12'h000;
      end
      else
      begin
         if (wr_m)
            hi_q <= {r[3], 1'b0, r[2], 1'b0, r[1], 1'b0, r[0], 1'b0};
         if (wr_v)
            val_q <= r;
         if (wr_k)
            mask_q <= r;
         len_q <= |(out_p ^ out_m) ? len_q + 12'h001 : 12'h000;
      end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_rd(logic [7:0] a);
      reg_rd && reg_addr == a;
   endsequence
   sequence s_mod;
      mod_fault [*5];
   endsequence

   property p_rd_idle;
      !reg_rd |=> reg_rdata == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data without read");
   property p_pair_hi;
      s_rd(scp_pkg::REG_VSTAT) |=>
         (reg_rdata[7:0] & $past(hi_q) & $past(hi_q, 2)) == 8'h00;
   endproperty
   a_pair_hi: assert property (p_pair_hi)
      else $error("upper status of pair set");
   property p_wf_pv;
      s_rd(scp_pkg::REG_IN_PV) |=> (reg_rdata[7:0] & $past(in_wire_fault, 2)
         & $past(in_wire_fault, 3) & $past(in_wire_fault, 4)
         & $past(in_wire_fault, 5) & $past(in_wire_fault, 6)) == 8'h00;
   endproperty
   a_wf_pv: assert property (p_wf_pv)
      else $error("faulty input reads one");
   property p_mod_out;
      s_mod |-> out_p == 4'h0 && out_m == 4'h0;
   endproperty
   a_mod_out: assert property (p_mod_out)
      else $error("output on during module fault");
   property p_mod_vstat;
      s_mod ##0 s_rd(scp_pkg::REG_VSTAT) |=> reg_rdata == 32'h0;
   endproperty
   a_mod_vstat: assert property (p_mod_vstat)
      else $error("status valid during module fault");
   property p_pulse_len;
      int'(len_q) <= scp_pkg::READBACK_CYC;
   endproperty
   a_pulse_len: assert property (p_pulse_len)
      else $error("test pulse too long");
   property p_both_cmd;
      (out_p & out_m & ~(val_q | $past(val_q))) == 4'h0;
   endproperty
   a_both_cmd: assert property (p_both_cmd)
      else $error("both switches on without command");
   property p_irq_off;
      mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !irq;
   endproperty
   a_irq_off: assert property (p_irq_off)
      else $error("interrupt while all masked");
endmodule
`default_nettype wire

// >>> scp_field.sv
// field side: switch readback with a stuck-off option
`default_nettype none
module scp_field (
   // switches from the block
   input  wire logic [3:0] out_p,
   input  wire logic [3:0] out_m,
   // fault injection
   input  wire logic [3:0] stuck,
   // readback
   output logic      [3:0] out_p_fb,
   output logic      [3:0] out_m_fb
);
   timeunit 1ns;
   timeprecision 1ns;
   // a stuck switch never reads back on
   assign out_p_fb = out_p & ~stuck;
   assign out_m_fb = out_m & ~stuck;
endmodule
`default_nettype wire

// >>> scp_top_test.sv
// bench of the passivation block
`default_nettype none
module scp_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [7:0]  in_pin = 8'h00;
   logic [7:0]  in_wire_fault = 8'h00;
   logic [3:0]  out_p;
   logic [3:0]  out_m;
   logic [3:0]  out_p_fb;
   logic [3:0]  out_m_fb;
   logic [3:0]  stuck = 4'h0;
   logic        mod_fault = 1'b0;
   logic [3:0]  diag = 4'h0;
   logic        irq;
   int          mismatches = 0;
   int          num_checks = 0;
   int          len;

   always #25 clk = ~clk;

   scp_top #(.MS_CYC_P(20), .TEST_PERIOD_P(6000)) dut (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .in_pin(in_pin), .in_wire_fault(in_wire_fault), .out_p(out_p),
      .out_m(out_m), .out_p_fb(out_p_fb), .out_m_fb(out_m_fb),
      .out_diag_fault(diag), .mod_fault(mod_fault), .irq(irq)
   );
   scp_field field (
      .out_p(out_p), .out_m(out_m), .stuck(stuck),
      .out_p_fb(out_p_fb), .out_m_fb(out_m_fb)
   );

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("BAD at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic set(input logic [7:0] p, input logic [7:0] f,
                      input logic m);
      @(posedge clk);
      in_pin        <= p;
      in_wire_fault <= f;
      mod_fault     <= m;
      repeat (6) @(posedge clk);
   endtask
   // waits until the chosen switch is on at all four outputs, returns how many cycles it stays so
   task automatic pulse(input logic m, output int n);
      int k;
      k = 0;
      n = 0;
      while ((m ? out_m : out_p) !== 4'hF && k < 8000)
      begin
         @(posedge clk);
         #1 k++;
      end
      while ((m ? out_m : out_p) === 4'hF)
      begin
         chk(32'(m ? out_p : out_m), 32'h5);
         @(posedge clk);
         #1 n++;
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (40000) @(posedge clk);
      mismatches++;
      test_done();
   end

   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rc(8'h00, 32'hFFF);
      rc(8'h04, 32'h0);
      rc(8'h08, 32'hA);
      rc(8'h24, 32'h0);
      rc(8'h18, 32'h0);
      rc(8'h30, 32'h0);
      set(8'hA5, 8'h00, 1'b0);
      rc(8'h10, 32'hA5);
      wr(8'h00, 32'hFFB);
      rc(8'h14, 32'hFFB);
      wr(8'h00, 32'hFFF);
      // wire fault, sticky passivation, reintegration
      wr(8'h24, 32'h1);
      set(8'hA5, 8'h01, 1'b0);
      rc(8'h18, 32'h1);
      rc(8'h10, 32'hA4);
      rc(8'h14, 32'hFFE);
      chk(32'(irq), 32'h1);
      wr(8'h1C, 32'h1);
      rc(8'h18, 32'h1);
      set(8'hA5, 8'h00, 1'b0);
      rc(8'h10, 32'hA4);
      wr(8'h20, 32'h1);
      rc(8'h18, 32'h1);
      chk(32'(irq), 32'h0);
      wr(8'h1C, 32'h1);
      rc(8'h18, 32'h0);
      rc(8'h20, 32'h8);
      // redundant pairs: 0 equivalent, 1 non-equivalent
      wr(8'h08, 32'hFF);
      wr(8'h04, 32'h23);
      set(8'h07, 8'h00, 1'b0);
      rc(8'h10, 32'h5);
      rc(8'h14, 32'hFF5);
      set(8'h08, 8'h00, 1'b0);
      rc(8'h10, 32'h0);
      wr(8'h08, 32'h2);
      set(8'h05, 8'h00, 1'b0);
      rc(8'h18, 32'h0);
      repeat (60) @(posedge clk);
      rc(8'h18, 32'h1);
      wr(8'h04, 32'h0);
      wr(8'h1C, 32'h1);
      rc(8'h18, 32'h0);
      wr(8'h20, 32'hF);
      // outputs and test pulses
      wr(8'h0C, 32'h5);
      repeat (2) @(posedge clk);
      #1 chk(32'({out_p, out_m}), 32'h55);
      pulse(1'b0, len);
      chk(32'(len), scp_pkg::READBACK_CYC);
      pulse(1'b1, len);
      chk(32'(len), scp_pkg::READBACK_CYC);
      @(posedge clk);
      stuck <= 4'h2;
      pulse(1'b0, len);
      rc(8'h18, 32'h200);
      wr(8'h0C, 32'hF);
      rc(8'h14, 32'hDFF);
      chk(32'({out_p, out_m, irq}), 32'h1BA);
      @(posedge clk);
      stuck <= 4'h0;
      wr(8'h1C, 32'h200);
      rc(8'h18, 32'h0);
      // module fault
      set(8'hFF, 8'h00, 1'b1);
      rc(8'h18, 32'h10000);
      rc(8'h10, 32'h0);
      rc(8'h14, 32'h0);
      chk(32'({out_p, out_m, irq}), 32'h0);
      set(8'hFF, 8'h00, 1'b0);
      wr(8'h1C, 32'h10000);
      rc(8'h14, 32'hFFF);
      chk(32'({out_p, out_m}), 32'hFF);
      // output diagnostic fault, reintegration refused while present
      @(posedge clk);
      diag <= 4'h1;
      repeat (4) @(posedge clk);
      wr(8'h1C, 32'h100);
      rc(8'h18, 32'h100);
      chk(32'({out_p, out_m}), 32'hEE);
      @(posedge clk);
      diag <= 4'h0;
      repeat (3) @(posedge clk);
      wr(8'h1C, 32'h100);
      rc(8'h18, 32'h0);
      test_done();
   end
endmodule

bind scp_top scp_chk u_chk (
   .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .in_wire_fault(in_wire_fault), .out_p(out_p), .out_m(out_m),
   .mod_fault(mod_fault), .irq(irq)
);
`default_nettype wire
